// [hw/gmpi_pkg.sv]
// Shared constants, types and step functions of the byte link
package gmpi_pkg;
	localparam int CLK_NS         = 10;
	localparam int GIG_PERIOD_NS  = 8;
	localparam int FAST_PERIOD_NS = 40;
	localparam int SLOW_PERIOD_NS = 400;
	localparam int BYTE_W         = 8;
	localparam int NIB_W          = 4;
	localparam int CNT_W          = 5;
	localparam logic [1:0] STRAP_SETTLE = 2'h2;

	typedef enum logic [2:0]
	{
		SPD_10   = 3'b001,
		SPD_100  = 3'b010,
		SPD_1000 = 3'b100
	} gmpi_speed_type;

	// Half period of a link clock, rounded down, at least one cycle
	function automatic logic [CNT_W-1:0] half_cycles(input int period_ns);
		int c;
		c = period_ns / 2 / CLK_NS;
		if (c < 1)
			c = 1;
		return c[CNT_W-1:0];
	endfunction : half_cycles

	localparam logic [CNT_W-1:0] GIG_HALF  = half_cycles(GIG_PERIOD_NS);
	localparam logic [CNT_W-1:0] FAST_HALF = half_cycles(FAST_PERIOD_NS);
	localparam logic [CNT_W-1:0] SLOW_HALF = half_cycles(SLOW_PERIOD_NS);

	function automatic logic [CNT_W-1:0] half_of(input gmpi_speed_type sp);
		logic [CNT_W-1:0] h;
		h = SLOW_HALF;
		if (sp == SPD_1000)
			h = GIG_HALF;
		else if (sp == SPD_100)
			h = FAST_HALF;
		return h;
	endfunction : half_of

	typedef struct packed
	{
		logic              dv;
		logic              er;
		logic [BYTE_W-1:0] d;
		logic              ph;
		logic [NIB_W-1:0]  hi;
		logic              take;
	} gmpi_ser_type;

	typedef struct packed
	{
		logic              valid;
		logic              err;
		logic [BYTE_W-1:0] data;
		logic              ph;
		logic [NIB_W-1:0]  lo;
	} gmpi_des_type;

	// One symbol out: a byte, or low then high nibble
	function automatic gmpi_ser_type ser_step(input gmpi_ser_type s,
		input logic gig, input logic valid,
		input logic [BYTE_W-1:0] data, input logic err);
		gmpi_ser_type n;
		n = s;
		if (gig)
		begin
			n.dv = valid;
			n.d = valid ? data : '0;
			n.er = err & valid;
			n.take = valid;
			n.ph = 1'b0;
		end
		else if (s.ph)
		begin
			n.d = {4'h0, s.hi};
			n.ph = 1'b0;
		end
		else
		begin
			n.dv = valid;
			n.d = valid ? {4'h0, data[3:0]} : '0;
			n.hi = data[7:4];
			n.er = err & valid;
			n.take = valid;
			n.ph = valid;
		end
		return n;
	endfunction : ser_step

	// One symbol in: a byte, or low then high nibble
	function automatic gmpi_des_type des_step(input gmpi_des_type s,
		input logic gig, input logic dv,
		input logic [BYTE_W-1:0] d, input logic er);
		gmpi_des_type n;
		n = s;
		if (!dv)
			n.ph = 1'b0;
		else if (gig)
		begin
			n.valid = 1'b1;
			n.data = d;
			n.err = er;
		end
		else if (!s.ph)
		begin
			n.lo = d[3:0];
			n.err = er;
			n.ph = 1'b1;
		end
		else
		begin
			n.valid = 1'b1;
			n.data = {d[3:0], s.lo};
			n.err = s.err | er;
			n.ph = 1'b0;
		end
		return n;
	endfunction : des_step
endpackage : gmpi_pkg

// [hw/gmpi_link_if.sv]
// Pin-level link between the transceiver end and the MAC end
`timescale 1ns/100ps
interface gmpi_link_if;
	logic       gtx_clk;
	logic       tx_en;
	logic       tx_er;
	logic [7:0] txd;
	logic       tx_clk;
	logic       tx_clk_oe;
	logic       rx_clk;
	logic       rx_dv;
	logic       rx_er;
	logic [7:0] rxd;
	logic       crs;
	logic       col;
	logic       phy_oe;
	logic       tx_clk_w;
	logic       rx_clk_w;
	logic       rx_dv_w;
	logic       rx_er_w;
	logic [7:0] rxd_w;
	logic       crs_w;
	logic       col_w;

	// Undriven pins read low
	assign tx_clk_w = tx_clk_oe & tx_clk;
	assign rx_clk_w = phy_oe & rx_clk;
	assign rx_dv_w  = phy_oe & rx_dv;
	assign rx_er_w  = phy_oe & rx_er;
	assign rxd_w    = phy_oe ? rxd : 8'h00;
	assign crs_w    = phy_oe & crs;
	assign col_w    = phy_oe & col;

	modport phy
	(
		input  gtx_clk, tx_en, tx_er, txd,
		output tx_clk, tx_clk_oe, rx_clk, rx_dv, rx_er, rxd, crs, col,
		output phy_oe
	);
	modport mac
	(
		output gtx_clk, tx_en, tx_er, txd,
		input  tx_clk_w, rx_clk_w, rx_dv_w, rx_er_w, rxd_w, crs_w, col_w
	);
endinterface : gmpi_link_if

// [hw/gmpi_mac.sv]
// MAC end of the byte link
`timescale 1ns/100ps
module gmpi_mac
(
	input  wire logic                    sys_clk,
	input  wire logic                    rstn,
	gmpi_link_if.mac                     link,
	input  wire gmpi_pkg::gmpi_speed_type speed,
	input  wire logic                    tx_valid,
	input  wire logic [7:0]              tx_data,
	input  wire logic                    tx_err,
	output logic                         tx_take,
	output logic                         rx_valid,
	output logic [7:0]                   rx_data,
	output logic                         rx_err,
	output logic                         crs_sync,
	output logic                         col_sync
);
	import gmpi_pkg::*;

	typedef struct packed
	{
		logic [CNT_W-1:0]   gtx_cnt;
		logic               gtx_clk;
		logic [2:0]         tck_sy;
		logic [2:0]         rck_sy;
		logic [1:0]         dv_sy;
		logic [1:0]         er_sy;
		logic [1:0][7:0]    rxd_sy;
		logic [1:0]         crs_sy;
		logic [1:0]         col_sy;
		gmpi_ser_type       tx;
		gmpi_des_type       rx;
	} gmpi_mac_state_type;

	gmpi_mac_state_type s;
	gmpi_mac_state_type next_s;

	always_comb
	begin
		logic gig;
		logic wrap;
		logic tx_edge;
		gig = (speed == SPD_1000);
		wrap = (s.gtx_cnt >= half_of(speed) - 5'h01);
		// Data changes half a period before the sampling edge
		tx_edge = gig ? (s.gtx_clk & wrap)
			: (s.tck_sy[1] & ~s.tck_sy[2]); // RULE5
		next_s = s;
		next_s.tck_sy = {s.tck_sy[1:0], link.tx_clk_w};
		next_s.rck_sy = {s.rck_sy[1:0], link.rx_clk_w};
		next_s.dv_sy = {s.dv_sy[0], link.rx_dv_w};
		next_s.er_sy = {s.er_sy[0], link.rx_er_w};
		next_s.rxd_sy = {s.rxd_sy[0], link.rxd_w};
		next_s.crs_sy = {s.crs_sy[0], link.crs_w}; // RULE7
		next_s.col_sy = {s.col_sy[0], link.col_w}; // RULE7
		// Own 1000 Mbps transmit clock
		if (!gig)
		begin
			next_s.gtx_cnt = '0;
			next_s.gtx_clk = 1'b0;
		end
		else if (wrap)
		begin
			next_s.gtx_cnt = '0;
			next_s.gtx_clk = ~s.gtx_clk; // RULE3
		end
		else
			next_s.gtx_cnt = s.gtx_cnt + 5'h01;
		next_s.tx.take = 1'b0;
		if (tx_edge)
			next_s.tx = ser_step(s.tx, gig, tx_valid,
				tx_data, tx_err); // RULE1 RULE13
		next_s.rx.valid = 1'b0;
		if (s.rck_sy[1] & ~s.rck_sy[2])
			next_s.rx = des_step(s.rx, gig, s.dv_sy[1],
				s.rxd_sy[1], s.er_sy[1]); // RULE6
	end

	always_ff @(posedge sys_clk or negedge rstn)
	begin
		if (!rstn)
			s <= '0;
		else
			s <= next_s;
	end

	assign link.gtx_clk = s.gtx_clk;
	assign link.tx_en   = s.tx.dv;
	assign link.tx_er   = s.tx.er;
	assign link.txd     = s.tx.d;
	assign tx_take      = s.tx.take;
	assign rx_valid     = s.rx.valid;
	assign rx_data      = s.rx.data;
	assign rx_err       = s.rx.err;
	assign crs_sync     = s.crs_sy[1];
	assign col_sync     = s.col_sy[1];
endmodule : gmpi_mac

// [hw/gmpi_phy.sv]
// Transceiver end of the byte link
`timescale 1ns/100ps

// Summary of operation
// [RULE1] Gigabit paths are separate byte-wide groups
// [RULE2] Gigabit speed is never half duplex
// [RULE3] MAC drives the gigabit transmit clock
// [RULE4] Transceiver drives the receive clock
// [RULE5] Transmit group sampled on transmit clock rise; below gigabit the transceiver samples it on transmit clock fall
// [RULE6] Receive group valid at receive clock rise
// [RULE7] Carrier and collision unrelated to link clocks
// [RULE8] Interface strap low selects this interface
// [RULE9] Reference clock strap high enables reference clock
// [RULE10] Isolate floats outputs, ignores inputs, except refclock
// [RULE11] Link has twenty-four signals; this link carries twenty-five
// [RULE12] Transceiver sources transmit clock below gigabit
// [RULE13] Below gigabit the paths carry nibbles
// [RULE14] One byte per clock, valid held whole frame
module gmpi_phy
(
	input  wire logic                    sys_clk,
	input  wire logic                    rstn,
	gmpi_link_if.phy                     link,
	input  wire gmpi_pkg::gmpi_speed_type speed,
	input  wire logic                    half_duplex_req,
	input  wire logic                    isolate_bit,
	input  wire logic                    interface_select_strap,
	input  wire logic                    refclk_output_strap,
	input  wire logic                    line_rx_valid,
	input  wire logic [7:0]              line_rx_data,
	input  wire logic                    line_rx_err,
	output logic                         line_rx_take,
	output logic                         line_tx_valid,
	output logic [7:0]                   line_tx_data,
	output logic                         line_tx_err,
	input  wire logic                    line_crs,
	input  wire logic                    line_col,
	output logic                         gmii_mode,
	output logic                         refclk_enable,
	output logic                         refclk_output_pin,
	output logic                         half_duplex
);
	import gmpi_pkg::*;

	// Rise seen at the end of a pin synchroniser
	function automatic logic rose(input logic [2:0] sy);
		return sy[1] & ~sy[2];
	endfunction : rose

	typedef struct packed
	{
		// Pin synchronisers
		logic [2:0]         gtx_sy;
		logic [1:0]         en_sy;
		logic [1:0]         er_sy;
		logic [1:0][7:0]    txd_sy;
		logic [1:0]         sel_sy;
		logic [1:0]         ref_sy;
		// Strap capture
		logic [1:0]         settle;
		logic               strapped;
		logic               gmii_mode;
		logic               refclk_enable;
		logic               refclk_pin;
		// Link clock dividers
		logic [CNT_W-1:0]   rx_cnt;
		logic               rx_clk;
		logic [CNT_W-1:0]   tx_cnt;
		logic               tx_clk;
		// Symbol paths and status
		gmpi_ser_type       rx;
		gmpi_des_type       tx;
		logic               crs;
		logic               col;
		logic               oe;
		logic               tx_clk_oe;
		logic               half_duplex;
	} gmpi_phy_state_type;

	gmpi_phy_state_type s;
	gmpi_phy_state_type next_s;

	always_comb
	begin
		logic             gig;
		logic             active;
		logic [CNT_W-1:0] half;
		logic             rx_wrap;
		logic             tx_wrap;
		logic             tx_rise;
		logic             tx_fall;
		gig = (speed == SPD_1000);
		half = half_of(speed);
		active = s.gmii_mode & ~isolate_bit;
		rx_wrap = (s.rx_cnt >= half - 5'h01);
		tx_wrap = (s.tx_cnt >= half - 5'h01);
		tx_rise = gig & rose(s.gtx_sy);
		tx_fall = ~gig & s.tx_clk & tx_wrap;
		next_s = s;

		// Pin inputs through two flip-flops, the gigabit transmit clock through three
		next_s.gtx_sy = {s.gtx_sy[1:0], link.gtx_clk};
		next_s.en_sy = {s.en_sy[0], link.tx_en};
		next_s.er_sy = {s.er_sy[0], link.tx_er};
		next_s.txd_sy = {s.txd_sy[0], link.txd};
		next_s.sel_sy = {s.sel_sy[0], interface_select_strap};
		next_s.ref_sy = {s.ref_sy[0], refclk_output_strap};

		// Straps caught once, after they settle
		if (!s.strapped)
		begin
			if (s.settle == STRAP_SETTLE)
			begin
				next_s.strapped = 1'b1;
				next_s.gmii_mode = ~s.sel_sy[1]; // RULE8
				next_s.refclk_enable = s.ref_sy[1]; // RULE9
			end
			else
				next_s.settle = s.settle + 2'h1;
		end

		// Reference clock runs regardless of isolate
		next_s.refclk_pin = s.refclk_enable & ~s.refclk_pin; // RULE9 RULE10

		// Receive clock divider
		if (rx_wrap)
		begin
			next_s.rx_cnt = '0;
			next_s.rx_clk = ~s.rx_clk; // RULE4
		end
		else
			next_s.rx_cnt = s.rx_cnt + 5'h01;

		// Transmit clock divider, used below gigabit only
		if (gig)
		begin
			next_s.tx_cnt = '0;
			next_s.tx_clk = 1'b0;
		end
		else if (tx_wrap)
		begin
			next_s.tx_cnt = '0;
			next_s.tx_clk = ~s.tx_clk; // RULE12
		end
		else
			next_s.tx_cnt = s.tx_cnt + 5'h01;

		// Receive group cleared at once when inactive, else moves on fall
		next_s.rx.take = 1'b0;
		if (!active)
		begin
			next_s.rx = '0; // RULE10
		end
		else if (s.rx_clk & rx_wrap)
		begin
			next_s.rx = ser_step(s.rx, gig, line_rx_valid,
				line_rx_data, line_rx_err); // RULE6 RULE13 RULE14
		end

		// Transmit group capture
		next_s.tx.valid = 1'b0;
		if (!active)
		begin
			next_s.tx.ph = 1'b0; // RULE10
		end
		else if (tx_rise)
		begin
			next_s.tx = des_step(s.tx, 1'b1, s.en_sy[1],
				s.txd_sy[1], s.er_sy[1]); // RULE1 RULE5
		end
		else if (tx_fall)
		begin
			next_s.tx = des_step(s.tx, 1'b0, s.en_sy[1],
				s.txd_sy[1], s.er_sy[1]); // RULE13
		end

		// Duplex and carrier status
		next_s.half_duplex = half_duplex_req & ~gig; // RULE2
		next_s.crs = active & line_crs; // RULE7
		next_s.col = active & line_col & s.half_duplex; // RULE7
		next_s.oe = active; // RULE10 RULE11
		next_s.tx_clk_oe = active & ~gig; // RULE12
	end

	always_ff @(posedge sys_clk or negedge rstn)
	begin
		if (!rstn)
			s <= '0;
		else
			s <= next_s;
	end

	// Link pins
	assign link.tx_clk      = s.tx_clk;
	assign link.tx_clk_oe   = s.tx_clk_oe;
	assign link.rx_clk      = s.rx_clk;
	assign link.rx_dv       = s.rx.dv;
	assign link.rx_er       = s.rx.er;
	assign link.rxd         = s.rx.d;
	assign link.crs         = s.crs;
	assign link.col         = s.col;
	assign link.phy_oe      = s.oe;
	// Line side and status
	assign line_rx_take     = s.rx.take;
	assign line_tx_valid    = s.tx.valid;
	assign line_tx_data     = s.tx.data;
	assign line_tx_err      = s.tx.err;
	assign gmii_mode        = s.gmii_mode;
	assign refclk_enable    = s.refclk_enable;
	assign refclk_output_pin = s.refclk_pin;
	assign half_duplex      = s.half_duplex;
endmodule : gmpi_phy

// [test/gmpi_link_properties.sv]
// Wire-level checks on the link between the two ends
`timescale 1ns/100ps
module gmpi_link_properties
(
	input wire logic       sys_clk,
	input wire logic       rstn,
	input wire logic       gtx_clk,
	input wire logic       tx_en,
	input wire logic       tx_er,
	input wire logic [7:0] txd,
	input wire logic       tx_clk_oe,
	input wire logic       rx_clk,
	input wire logic       rx_dv,
	input wire logic       rx_er,
	input wire logic [7:0] rxd,
	input wire logic       crs,
	input wire logic       col,
	input wire logic       phy_oe
);
	default clocking cb @(posedge sys_clk);
	endclocking
	default disable iff (!rstn);

	sequence s_gtx_pulse;
		gtx_clk ##1 !gtx_clk;
	endsequence
	sequence s_rx_edge;
		##[1:20] $changed(rx_clk);
	endsequence

	property p_gtx_half;
		$rose(gtx_clk) |-> s_gtx_pulse;
	endproperty
	a_gtx_half: assert property (p_gtx_half)
		else $error("transmit clock high too long");
	property p_rx_clk_runs;
		$changed(rx_clk) |-> s_rx_edge;
	endproperty
	a_rx_clk_runs: assert property (p_rx_clk_runs)
		else $error("receive clock stopped");
	property p_tx_at_fall;
		$changed({tx_en, tx_er, txd}) && (gtx_clk || $past(gtx_clk))
			|-> $fell(gtx_clk);
	endproperty
	a_tx_at_fall: assert property (p_tx_at_fall)
		else $error("transmit group moved off clock fall");
	property p_rx_at_fall;
		phy_oe && $past(phy_oe) && $changed({rx_dv, rx_er, rxd})
			|-> $fell(rx_clk);
	endproperty
	a_rx_at_fall: assert property (p_rx_at_fall)
		else $error("receive group moved off clock fall");
	property p_iso_rx;
		!phy_oe |-> !rx_dv && !rx_er && rxd == 8'h00;
	endproperty
	a_iso_rx: assert property (p_iso_rx)
		else $error("receive group live while disabled");
	property p_iso_misc;
		!phy_oe |-> !tx_clk_oe && !crs && !col;
	endproperty
	a_iso_misc: assert property (p_iso_misc)
		else $error("outputs live while disabled");
	property p_gig_no_col;
		gtx_clk |-> !col;
	endproperty
	a_gig_no_col: assert property (p_gig_no_col)
		else $error("collision at gigabit speed");
	property p_gig_no_txclk;
		gtx_clk |-> !tx_clk_oe;
	endproperty
	a_gig_no_txclk: assert property (p_gig_no_txclk)
		else $error("transmit clock driven at gigabit");
	property p_mii_nibble;
		tx_clk_oe |-> txd[7:4] == 4'h0 && rxd[7:4] == 4'h0;
	endproperty
	a_mii_nibble: assert property (p_mii_nibble)
		else $error("upper nibble used below gigabit");
endmodule : gmpi_link_properties

// [test/gmii_phy_interface_tb.sv]
// Bench joining both ends of the byte link
`timescale 1ns/100ps
module gmii_phy_interface_tb;
	import gmpi_pkg::*;
	logic           sys_clk = 1'b0;
	logic           rstn = 1'b0;
	gmpi_speed_type speed = SPD_1000;
	logic           half_duplex_req = 1'b1;
	logic           isolate_bit = 1'b0;
	logic           interface_select_strap = 1'b0;
	logic           refclk_output_strap = 1'b1;
	logic           line_rx_valid = 1'b0, line_rx_err = 1'b0;
	logic [7:0]     line_rx_data = 8'h00, tx_data = 8'h00;
	logic           tx_valid = 1'b0, tx_err = 1'b0;
	logic           line_crs = 1'b0, line_col = 1'b0;
	logic           line_rx_take, line_tx_valid, line_tx_err, tx_take;
	logic [7:0]     line_tx_data, rx_data;
	logic           gmii_mode, refclk_enable, refclk_output_pin;
	logic           half_duplex, rx_valid, rx_err, crs_sync, col_sync;
	logic [8:0]     mac_q[$], phy_q[$];
	gmpi_speed_type spds[3] = '{SPD_1000, SPD_100, SPD_10};
	int             n_mismatch = 0, n_compared = 0, n_take = 0, cycles = 0;
	logic           p;

	gmpi_link_if gmpi_link_if_inst();
	gmpi_phy gmpi_phy_inst(.sys_clk, .rstn, .link(gmpi_link_if_inst),
		.speed, .half_duplex_req, .isolate_bit, .interface_select_strap,
		.refclk_output_strap, .line_rx_valid, .line_rx_data, .line_rx_err,
		.line_rx_take, .line_tx_valid, .line_tx_data, .line_tx_err,
		.line_crs, .line_col, .gmii_mode, .refclk_enable,
		.refclk_output_pin, .half_duplex);
	gmpi_mac gmpi_mac_inst(.sys_clk, .rstn, .link(gmpi_link_if_inst),
		.speed, .tx_valid, .tx_data, .tx_err, .tx_take, .rx_valid,
		.rx_data, .rx_err, .crs_sync, .col_sync);
	gmpi_link_properties gmpi_link_properties_inst(.sys_clk, .rstn,
		.gtx_clk(gmpi_link_if_inst.gtx_clk),
		.tx_en(gmpi_link_if_inst.tx_en), .tx_er(gmpi_link_if_inst.tx_er),
		.txd(gmpi_link_if_inst.txd),
		.tx_clk_oe(gmpi_link_if_inst.tx_clk_oe),
		.rx_clk(gmpi_link_if_inst.rx_clk),
		.rx_dv(gmpi_link_if_inst.rx_dv), .rx_er(gmpi_link_if_inst.rx_er),
		.rxd(gmpi_link_if_inst.rxd), .crs(gmpi_link_if_inst.crs),
		.col(gmpi_link_if_inst.col), .phy_oe(gmpi_link_if_inst.phy_oe));

	always #5 sys_clk = ~sys_clk;

	task automatic stop_test();
		$display("Compared %0d, mismatched %0d", n_compared, n_mismatch);
		if (n_mismatch == 0 && n_compared > 0)
			$display("Finished cleanly");
		else
			$display("Finished with errors");
		$finish;
	endtask : stop_test

	// Collect delivered bytes, count takes, cut hangs short
	always @(posedge sys_clk)
	begin
		if (rx_valid === 1'b1)
			mac_q.push_back({rx_err, rx_data});
		if (line_tx_valid === 1'b1)
			phy_q.push_back({line_tx_err, line_tx_data});
		if (line_rx_take === 1'b1)
			n_take++;
		cycles++;
		if (cycles == 20000)
		begin
			n_mismatch++;
			$display("FAIL t=%0t got=%h exp=%h", $time, cycles, 20000);
			stop_test();
		end
	end

	task automatic check_bit(input logic got, input logic exp);
		n_compared++;
		if (got !== exp)
		begin
			n_mismatch++;
			$display("FAIL t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask : check_bit

	task automatic check_sym(input logic [8:0] got, input logic [8:0] exp);
		n_compared++;
		if (got !== exp)
		begin
			n_mismatch++;
			$display("FAIL t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask : check_sym

	task automatic reset_to(input gmpi_speed_type sp, input logic sel,
		input logic ref_on);
		rstn <= 1'b0;
		speed <= sp;
		interface_select_strap <= sel;
		refclk_output_strap <= ref_on;
		repeat (20) @(posedge sys_clk);
		rstn <= 1'b1;
		repeat (8) @(posedge sys_clk);
		mac_q.delete();
		phy_q.delete();
	endtask : reset_to

	// Offer one byte and hold it until taken
	task automatic put(input bit side, input logic [7:0] d, input logic e);
		int n;
		n = 0;
		if (side)
		begin
			line_rx_valid <= 1'b1;
			line_rx_data <= d;
			line_rx_err <= e;
		end
		else
		begin
			tx_valid <= 1'b1;
			tx_data <= d;
			tx_err <= e;
		end
		do
		begin
			@(posedge sys_clk);
			n++;
		end
		while ((side ? line_rx_take : tx_take) !== 1'b1 && n < 3000);
		if ((side ? line_rx_take : tx_take) !== 1'b1)
		begin
			n_mismatch++;
			$display("FAIL t=%0t got=%h exp=%h", $time, 1'b0, 1'b1);
		end
	endtask : put

	// Four back-to-back bytes, error on the third
	task automatic frame(input bit side, input logic [7:0] base);
		for (int i = 0; i < 4; i++)
			put(side, base + 8'(i * 59), i == 2);
		if (side)
			line_rx_valid <= 1'b0;
		else
			tx_valid <= 1'b0;
	endtask : frame

	initial
	begin
		int n;
		for (int s = 0; s < 3; s++)
		begin
			reset_to(spds[s], 1'b0, 1'b1);
			check_bit(gmii_mode, 1'b1);
			check_bit(refclk_enable, 1'b1);
			check_bit(half_duplex, s != 0);
			p = refclk_output_pin;
			@(posedge sys_clk);
			check_bit(refclk_output_pin, ~p);
			fork
				frame(1'b1, 8'ha5 + 8'(s));
				frame(1'b0, 8'h3c + 8'(s));
			join
			n = 0;
			while ((mac_q.size() < 4 || phy_q.size() < 4) && n < 1000)
			begin
				@(posedge sys_clk);
				n++;
			end
			check_sym(9'(mac_q.size()), 9'h004);
			check_sym(9'(phy_q.size()), 9'h004);
			for (int i = 0; i < 4; i++)
			begin
				check_sym(mac_q[i], {i == 2, 8'ha5 + 8'(s) + 8'(i * 59)});
				check_sym(phy_q[i], {i == 2, 8'h3c + 8'(s) + 8'(i * 59)});
			end
			line_crs <= 1'b1;
			line_col <= 1'b1;
			repeat (8) @(posedge sys_clk);
			check_bit(crs_sync, 1'b1);
			check_bit(col_sync, s != 0);
			line_crs <= 1'b0;
			line_col <= 1'b0;
		end
		isolate_bit <= 1'b1;
		repeat (4) @(posedge sys_clk);
		check_bit(gmpi_link_if_inst.phy_oe, 1'b0);
		p = refclk_output_pin;
		n_take = 0;
		line_rx_valid <= 1'b1;
		line_rx_data <= 8'h81;
		@(posedge sys_clk);
		check_bit(refclk_output_pin, ~p);
		repeat (100) @(posedge sys_clk);
		check_bit(n_take == 0, 1'b1);
		isolate_bit <= 1'b0;
		put(1'b1, 8'h81, 1'b0);
		line_rx_valid <= 1'b0;
		repeat (2) @(posedge sys_clk);
		check_bit(n_take == 1, 1'b1);
		reset_to(SPD_1000, 1'b1, 1'b0);
		check_bit(gmii_mode, 1'b0);
		check_bit(refclk_enable, 1'b0);
		p = refclk_output_pin;
		@(posedge sys_clk);
		check_bit(refclk_output_pin, p);
		stop_test();
	end
endmodule : gmii_phy_interface_tb
